/* File: rtl/pwm_pkg.sv */
// shared constants for the dithered 6+2 pulse width modulator
// assumes a 100 MHz system clock used directly as the prescaler source
//
// How it works
// - run select 00 forces low, 01 forces high, 1x runs the modulator
// - first cycle after enable may be wrong; later cycles are exact
// - divider select picks source clock divided by 1,2,4,8,16,32,64,128
// - control bits 5 to 3 do not exist and always read zero
// - an 8-bit duty word sets the duty of one whole output cycle
// - duty writes act at once; only the current cycle may be disturbed
// - one output cycle lasts 256 counter clock periods
// - four sub-cycles 0..3 run in order, then wrap to sub-cycle 0
// - each sub-cycle lasts 64 counter clock periods
// - coarse duty is duty word bits 7 down to 2
// - fine duty is duty word bits 1 down to 0
// - sub-cycle i is active coarse+1 clocks if i below fine, else coarse
// - hardware splits sub-cycles itself; software only sets registers
package pwm_pkg;

  // -------------------------------------------------------------------
  // register map, byte addresses on a 32-bit wishbone bus
  // -------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] DUTY_OFFSET   = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int          RUN_SEL_MSB   = 7;
  localparam int          RUN_SEL_LSB   = 6;
  localparam int          DIV_SEL_MSB   = 2;
  localparam int          DIV_SEL_LSB   = 0;
  localparam int          COARSE_MSB    = 7;
  localparam int          COARSE_LSB    = 2;
  localparam int          FINE_MSB      = 1;
  localparam int          FINE_LSB      = 0;
  localparam int          ST_WAVE_BIT   = 8;
  localparam int          ST_RUN_BIT    = 9;
  localparam int          ST_SETTLE_BIT = 10;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  DUTY_RESET    = 8'h00;

  // -------------------------------------------------------------------
  // timing counts, in counter clock periods
  // -------------------------------------------------------------------
  localparam int          CYCLE_CLOCKS  = 256;
  localparam int          SUB_CLOCKS    = 64;
  localparam int          CNT_W         = $clog2(CYCLE_CLOCKS);
  localparam int          POS_W         = $clog2(SUB_CLOCKS);
  localparam int          PSC_W         = 7;

  // output behaviour, gray along idle low -> idle high -> running
  typedef enum logic [1:0] {
    MODE_LOW  = 2'h0,
    MODE_HIGH = 2'h1,
    MODE_RUN  = 2'h3
  } mode_t;

endpackage

/* File: rtl/pwm_prescaler.sv */
// counter clock prescaler: turns the source clock into a one-cycle tick
// assumes the source clock is the module clock; cleared while idle
`timescale 1ns/1ns
module pwm_prescaler (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] div_sel_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [pwm_pkg::PSC_W-1:0] cnt;
  } psc_state_t;

  psc_state_t                st_r;
  psc_state_t                st_nxt;
  logic [pwm_pkg::PSC_W-1:0] mask;

  // tick when the low div_sel bits of the count are all ones
  // select 011 gives divide by 8 so that each step doubles the ratio
  always_comb begin
    mask       = pwm_pkg::PSC_W'((8'h01 << div_sel_i) - 8'h01);
    tick_o     = run_i && ((st_r.cnt & mask) == mask);
    st_nxt     = st_r;
    st_nxt.cnt = run_i ? st_r.cnt + 7'h01 : 7'h00;
  end

  // runs on the source clock itself, no derived clock
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* File: rtl/pwm_engine.sv */
// 256-step cycle counter split into four 64-step sub-cycles
// assumes duty is the live register value so changes act at once
`timescale 1ns/1ns
module pwm_engine (
  input  wire logic                     clock_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     run_i,
  input  wire logic                     tick_i,
  input  wire logic [7:0]               duty_i,
  output logic [pwm_pkg::CNT_W-1:0]     count_o,
  output logic                          active_o,
  output logic                          wrap_o
);

  typedef struct packed {
    logic [pwm_pkg::CNT_W-1:0] cnt;
  } eng_state_t;

  eng_state_t                st_r;
  eng_state_t                st_nxt;
  logic [1:0]                sub;
  logic [pwm_pkg::POS_W-1:0] pos;
  logic [5:0]                coarse;
  logic [1:0]                fine;
  logic [pwm_pkg::POS_W:0]   width;

  // upper two count bits number the sub-cycle, lower six the position
  always_comb begin
    sub      = st_r.cnt[pwm_pkg::CNT_W-1:pwm_pkg::POS_W];
    pos      = st_r.cnt[pwm_pkg::POS_W-1:0];
    coarse   = duty_i[pwm_pkg::COARSE_MSB:pwm_pkg::COARSE_LSB];
    fine     = duty_i[pwm_pkg::FINE_MSB:pwm_pkg::FINE_LSB];
    // one extra clock in sub-cycles below the fine value
    width    = {1'b0, coarse} + {6'h00, (sub < fine)};
    // high from the start of the sub-cycle for width clocks
    active_o = run_i && ({1'b0, pos} < width);
    wrap_o   = run_i && tick_i && (st_r.cnt == 8'hff);
    count_o  = st_r.cnt;
    st_nxt   = st_r;
    if (!run_i) begin
      st_nxt.cnt = '0;
    end else if (tick_i) begin
      st_nxt.cnt = st_r.cnt + 8'h01;   // wraps to sub-cycle 0
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* File: rtl/dithered_pwm_six_plus_two.sv */
// top of the dithered 6+2 pulse width modulator with a wishbone slave
// assumes a classic wishbone master on clock_i and a load on the pin
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module dithered_pwm_six_plus_two (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // modulated pin
  output logic             waveform_output_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------

  // every flop of this module lives in one struct
  typedef struct packed {
    logic [1:0]    run_select_field;
    logic [2:0]    clock_divider_select;
    logic [7:0]    duty_register;
    pwm_pkg::mode_t mode;
    logic          settled;
    logic          wave;
    logic          ack;
    logic [31:0]   rdata;
  } top_state_t;

  top_state_t                  st_r;
  top_state_t                  st_nxt;

  // -------------------------------------------------------------------
  // internal nets
  // -------------------------------------------------------------------
  logic                        run;
  logic                        tick;
  logic [pwm_pkg::CNT_W-1:0]   count;
  logic                        active;
  logic                        wrap;
  logic                        req;
  logic                        wr_lane0;
  logic                        hit_ctrl;
  logic                        hit_duty;
  logic                        hit_status;
  logic [7:0]                  ctrl_view;
  logic [31:0]                 status_view;
  logic [31:0]                 read_mux;
  logic [7:0]                  ctrl_wdata;

  // -------------------------------------------------------------------
  // sub-blocks
  // -------------------------------------------------------------------

  // run follows the registered mode so both sub-blocks start together
  assign run = (st_r.mode == pwm_pkg::MODE_RUN);

  pwm_prescaler u_prescaler (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .run_i     (run),
    .div_sel_i (st_r.clock_divider_select),
    .tick_o    (tick)
  );

  pwm_engine u_engine (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .run_i    (run),
    .tick_i   (tick),
    .duty_i   (st_r.duty_register),
    .count_o  (count),
    .active_o (active),
    .wrap_o   (wrap)
  );

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------

  // a request is taken once; ack high gates the second cycle so the
  // same access is never seen twice while the master holds it
  assign req        = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign wr_lane0   = req && wb_we_i && wb_sel_i[0];
  assign hit_ctrl   = (wb_adr_i[3:2] == pwm_pkg::CTRL_OFFSET[3:2]);
  assign hit_duty   = (wb_adr_i[3:2] == pwm_pkg::DUTY_OFFSET[3:2]);
  assign hit_status = (wb_adr_i[3:2] == pwm_pkg::STATUS_OFFSET[3:2]);
  assign ctrl_wdata = wb_dat_i[7:0];

  // control readback, unimplemented bits 5..3 forced to zero
  assign ctrl_view = {st_r.run_select_field,
                      3'h0,
                      st_r.clock_divider_select};

  // status shows live counter, pin level, run and settle flags
  assign status_view = {21'h000000,
                        st_r.settled,
                        run,
                        st_r.wave,
                        count};

  // read selection; unmapped addresses read as zero
  always_comb begin
    read_mux = 32'h00000000;
    if (hit_ctrl) begin
      read_mux = {24'h000000, ctrl_view};
    end else if (hit_duty) begin
      read_mux = {24'h000000, st_r.duty_register};
    end else if (hit_status) begin
      read_mux = status_view;
    end
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------

  // register writes, mode tracking, settle flag and the pin level
  always_comb begin
    st_nxt = st_r;

    // ack for exactly one cycle per access, also for unmapped ones
    st_nxt.ack = req;
    if (req) begin
      st_nxt.rdata = read_mux;
    end

    // only byte lane 0 carries the 8-bit registers
    if (wr_lane0 && hit_ctrl) begin
      st_nxt.run_select_field =
        ctrl_wdata[pwm_pkg::RUN_SEL_MSB:pwm_pkg::RUN_SEL_LSB];
      st_nxt.clock_divider_select =
        ctrl_wdata[pwm_pkg::DIV_SEL_MSB:pwm_pkg::DIV_SEL_LSB];
    end

    // the new duty is used by the engine on the next clock, with no
    // wait for a cycle boundary, so one cycle may look odd
    if (wr_lane0 && hit_duty) begin
      st_nxt.duty_register = ctrl_wdata;
    end

    // mode follows the run select field one clock later
    case (st_r.run_select_field)
      2'h0: begin
        st_nxt.mode = pwm_pkg::MODE_LOW;
      end
      2'h1: begin
        st_nxt.mode = pwm_pkg::MODE_HIGH;
      end
      2'h2, 2'h3: begin
        st_nxt.mode = pwm_pkg::MODE_RUN;
      end
      default: begin
        st_nxt.mode = pwm_pkg::MODE_LOW;
      end
    endcase

    // settle flag: first full cycle after enable has ended; the counter
    // restarts at zero on enable so even the first cycle is usually
    // right, but software is told only to trust later ones
    if (!run) begin
      st_nxt.settled = 1'b0;
    end else if (wrap) begin
      st_nxt.settled = 1'b1;
    end

    // pin level per mode; idle modes stop modulation
    case (st_r.mode)
      pwm_pkg::MODE_LOW: begin
        st_nxt.wave = 1'b0;
      end
      pwm_pkg::MODE_HIGH: begin
        st_nxt.wave = 1'b1;
      end
      pwm_pkg::MODE_RUN: begin
        st_nxt.wave = active;
      end
      default: begin
        st_nxt.wave = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------

  // synchronous reset; all fields take their reset constants
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r.run_select_field     <=
        pwm_pkg::CTRL_RESET[pwm_pkg::RUN_SEL_MSB:pwm_pkg::RUN_SEL_LSB];
      st_r.clock_divider_select <=
        pwm_pkg::CTRL_RESET[pwm_pkg::DIV_SEL_MSB:pwm_pkg::DIV_SEL_LSB];
      st_r.duty_register        <= pwm_pkg::DUTY_RESET;
      st_r.mode                 <= pwm_pkg::MODE_LOW;
      st_r.settled              <= 1'b0;
      st_r.wave                 <= 1'b0;
      st_r.ack                  <= 1'b0;
      st_r.rdata                <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------

  // all outputs straight from flops; pin lags the counter by one clock
  assign wb_ack_o          = st_r.ack;
  assign wb_dat_o          = st_r.rdata;
  assign waveform_output_o = st_r.wave;

endmodule

/* File: dv/pwm_load.sv */
// load on the pin: logs the width and rise time of the first ten pulses
// assumes the pin is sampled on clock_i; clear_i empties the log
`timescale 1ns/1ns
module pwm_load (
  input  wire logic clock_i,
  input  wire logic clear_i,
  input  wire logic pin_i,
  output int        n_o,
  output int        wid_o  [0:9],
  output int        rise_o [0:9]
);
  // ----------------
  // pulse log
  // ----------------
  int   t    = 0;
  logic last = 1'b0;
  // a passive load only listens; software alone sets the registers
  always @(posedge clock_i) begin
    t <= t + 1;
    last <= pin_i;
    if (clear_i) begin
      n_o <= 0;
    end else if (pin_i && !last && n_o < 10) begin
      rise_o[n_o] <= t;
      n_o <= n_o + 1;
    end else if (!pin_i && last && n_o > 0) begin
      wid_o[n_o-1] <= t - rise_o[n_o-1];
    end
  end
endmodule

/* File: dv/pwm_checker_assertions.sv */
// checker on the ports of the modulator top
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ns
module pwm_checker (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        waveform_output_o
);
  // ----------------
  // shadow registers
  // ----------------
  logic [7:0] ctl_r;
  logic [7:0] dut_r;
  logic [9:0] quiet_r;
  logic [6:0] hi_r;
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr   = take & wb_we_i & wb_sel_i[0];
  // steady needs 512 quiet clocks: the first cycle after a write may be off
  wire steady = ctl_r[7] && ctl_r[2:0] == 3'h0 && quiet_r[9] &&
                dut_r[7:2] != 6'h00 && dut_r[7:2] != 6'h3f;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctl_r <= 8'h00;
      dut_r <= 8'h00;
      quiet_r <= 10'h000;
      hi_r <= 7'h00;
    end else begin
      if (wr && wb_adr_i[3:2] == 2'h0) ctl_r <= wb_dat_i[7:0];
      if (wr && wb_adr_i[3:2] == 2'h1) dut_r <= wb_dat_i[7:0];
      quiet_r <= wr ? 10'h000 : (quiet_r[9] ? quiet_r : quiet_r + 10'h001);
      hi_r <= waveform_output_o ? hi_r + 7'h01 : 7'h00;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // a write landing mid-window voids the check, hence the quiet term
  sequence next_sub;
    ##63 (!waveform_output_o || !quiet_r[9]) ##1 (waveform_output_o || !quiet_r[9]);
  endsequence
  ack_follows_a: assert property (take |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ctrl_gap_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0 |->
    wb_dat_o[31:8] == 24'h0 && wb_dat_o[5:3] == 3'h0)
    else $error("ctrl gap not zero");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h3 |->
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  hold_low_a: assert property ((ctl_r[7:6] == 2'h0)[*3] |-> !waveform_output_o)
    else $error("pin not low");
  hold_high_a: assert property ((ctl_r[7:6] == 2'h1)[*3] |-> waveform_output_o)
    else $error("pin not high");
  sub_period_a: assert property (steady && $rose(waveform_output_o) |-> next_sub)
    else $error("sub period wrong");
  pulse_width_a: assert property (steady && $fell(waveform_output_o) |->
    hi_r == {1'b0, dut_r[7:2]} || hi_r == {1'b0, dut_r[7:2]} + 7'h01)
    else $error("pulse width wrong");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=>
    !wb_ack_o && !waveform_output_o) else $error("reset state wrong");
endmodule
bind dithered_pwm_six_plus_two pwm_checker u_chk (.clock_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .waveform_output_o);

/* File: dv/tb_top.sv */
// self-checking bench: register accesses and pin timing via the load log
// assumes the design acks every access and the load logs the pin
`timescale 1ns/1ns
module tb_top;
  // ----------------
  // signals
  // ----------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        clr = 1'b0;
  logic [31:0] d;
  int          n;
  int          wid [0:9];
  int          rise [0:9];
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc_n = 0;
  logic [7:0]  duties [0:4] = '{8'h64, 8'h65, 8'h66, 8'h67, 8'h05};
  always #5 clk = ~clk;
  dithered_pwm_six_plus_two dut (.clock_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .waveform_output_o(pin));
  pwm_load load (.clock_i(clk), .clear_i(clr), .pin_i(pin), .n_o(n), .wid_o(wid),
    .rise_o(rise));
  // ----------------
  // tasks
  // ----------------
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; holds everything until ack is sampled
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= v;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // stop, clear the log, then run; pulses 4..7 form the second cycle
  task automatic run_case(input logic [7:0] dv, input logic [2:0] ps, input logic [1:0] md);
    xfer(1'b1, 4'h0, 32'h0, 4'hf, d);
    xfer(1'b1, 4'h4, {24'h0, dv}, 4'hf, d);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    xfer(1'b1, 4'h0, {24'h0, md, 3'h0, ps}, 4'h1, d);
    while (n < 9) @(posedge clk);
    for (int i = 0; i < 4; i++)
      check(wid[4+i], ((dv >> 2) + (i < dv[1:0])) << ps);
    check(rise[5] - rise[4], 64 << ps);
    check(rise[8] - rise[4], 256 << ps);
    // status: running, and settled once a whole cycle has wrapped
    xfer(1'b0, 4'h8, 32'h0, 4'hf, d);
    check(d[10:9], 2'h3);
    repeat (300) @(posedge clk);
  endtask
  // ----------------
  // timeout and tests
  // ----------------
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    xfer(1'b0, 4'h0, 32'h0, 4'hf, d);
    check(d, 32'h0);
    xfer(1'b0, 4'h4, 32'h0, 4'hf, d);
    check(d, 32'h0);
    xfer(1'b1, 4'h0, 32'hff, 4'hf, d);
    xfer(1'b0, 4'h0, 32'h0, 4'hf, d);
    check(d, 32'hc7);
    xfer(1'b1, 4'h4, 32'ha5, 4'hf, d);
    xfer(1'b1, 4'h4, 32'h11, 4'h0, d);
    xfer(1'b0, 4'h4, 32'h0, 4'hf, d);
    check(d, 32'ha5);
    xfer(1'b1, 4'hc, 32'hff, 4'hf, d);
    xfer(1'b0, 4'hc, 32'h0, 4'hf, d);
    check(d, 32'h0);
    xfer(1'b1, 4'h0, 32'h0, 4'hf, d);
    repeat (3) @(posedge clk);
    check(pin, 1'b0);
    xfer(1'b1, 4'h0, 32'h40, 4'hf, d);
    repeat (3) @(posedge clk);
    check(pin, 1'b1);
    for (int k = 0; k < 5; k++) run_case(duties[k], 3'h0, k[0] ? 2'h3 : 2'h2);
    for (int p = 1; p < 6; p++) run_case(8'h65, p[2:0], 2'h2);
    // undivided clock, so a low step lasts one clock and the pin reacts at once
    xfer(1'b1, 4'h0, 32'h80, 4'hf, d);
    xfer(1'b1, 4'h4, 32'h0, 4'hf, d);
    repeat (300) @(posedge clk);
    check(pin, 1'b0);
    xfer(1'b1, 4'h4, 32'hfc, 4'hf, d);
    repeat (4) if (pin !== 1'b1) @(posedge clk);
    check(pin, 1'b1);
    do_reset();
    xfer(1'b0, 4'h0, 32'h0, 4'hf, d);
    check(d, 32'h0);
    check(pin, 1'b0);
    // counter, pin, run and settle flags all cleared by the reset
    xfer(1'b0, 4'h8, 32'h0, 4'hf, d);
    check(d, 32'h0);
    print_verdict();
  end
endmodule
